// ===== src/ohc_top.sv
// operating hours counter with service interval alarm and register port
`timescale 1ns/1ps
`default_nettype none
module ohc_top import ohc_pkg::*; #(
    parameter int SCAN_CYCLES = OHC_SCAN_CYCLES,
    parameter int SCANS_PER_MIN = OHC_SCANS_PER_MIN
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic monitor_in,
    input wire logic svc_reset_in,
    input wire logic full_clear_in,
    input wire logic [OHC_IH_W-1:0] ref_hours,
    input wire logic [OHC_IW-1:0] keep_interval_in,
    input wire logic [OHC_IW-1:0] keep_remain_in,
    input wire logic [OHC_AW-1:0] keep_accum_in,
    output logic [OHC_IW-1:0] keep_interval_out,
    output logic [OHC_IW-1:0] keep_remain_out,
    output logic [OHC_AW-1:0] keep_accum_out,
    output logic alarm_out,
    input wire logic [OHC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    localparam int SCW = $clog2(SCAN_CYCLES);
    localparam int MCW = $clog2(SCANS_PER_MIN);

    typedef enum logic [1:0] {OHC_ST_IDLE, OHC_ST_MOD, OHC_ST_SPLIT} ohc_state_t;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [OHC_TOT_W-1:0] hm_total(input logic [OHC_AH_W-1:0] h,
                                                      input logic [OHC_M_W-1:0] m);
        hm_total = {6'h00, h} * OHC_MIN_PER_HOUR + {17'h00000, m};
    endfunction

    function automatic logic [OHC_AH_W-1:0] clamp_h(input logic [OHC_AH_W-1:0] v,
                                                    input logic [OHC_AH_W-1:0] lim);
        clamp_h = (v > lim) ? lim : v;
    endfunction

    function automatic logic [OHC_M_W-1:0] clamp_m(input logic [OHC_M_W-1:0] v);
        clamp_m = (v > OHC_MIN_MAX) ? OHC_MIN_MAX : v;
    endfunction

    logic [OHC_IH_W-1:0] int_h, next_int_h, rem_h, next_rem_h;
    logic [OHC_M_W-1:0] int_m, next_int_m, rem_m, next_rem_m, acc_m, next_acc_m;
    logic [OHC_AH_W-1:0] acc_h, next_acc_h;
    logic [OHC_CTRL_W-1:0] ctrl;
    logic [OHC_EV_W-1:0] status, mask;
    ohc_state_t state;
    logic load_pend, svc_prev, clr_prev, acc_full_q;
    logic [SCW-1:0] scan_cnt;
    logic [MCW-1:0] on_cnt;
    logic [31:0] rd_mux;

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    wire hit_ctrl = reg_addr == OHC_REG_CTRL;
    wire hit_int = reg_addr == OHC_REG_INTERVAL;
    wire hit_acc = reg_addr == OHC_REG_ACCUM;
    wire hit_rem = reg_addr == OHC_REG_REMAIN;
    wire hit_stat = reg_addr == OHC_REG_STATUS;
    wire hit_mask = reg_addr == OHC_REG_MASK;
    wire hit_state = reg_addr == OHC_REG_STATE;
    wire run_mode = ctrl[OHC_CTRL_RUN];
    wire policy_idle = ctrl[OHC_CTRL_POLICY];
    wire ref_sel = ctrl[OHC_CTRL_REF];
    wire int_wr = reg_wr & hit_int & ~load_pend;
    wire acc_wr = reg_wr & hit_acc & ~load_pend;
    wire preset_ok = acc_wr & ~run_mode & (state == OHC_ST_IDLE);
    wire preset_refused = acc_wr & ~preset_ok;

    wire [OHC_AH_W-1:0] wr_int_h = clamp_h({3'h0, reg_wdata[OHC_HRS_LSB +: OHC_IH_W]},
                                           OHC_INT_HRS_MAX);
    wire [OHC_M_W-1:0] wr_int_m = clamp_m(reg_wdata[OHC_IMIN_LSB +: OHC_M_W]);
    wire [OHC_AH_W-1:0] wr_acc_h = clamp_h(reg_wdata[OHC_HRS_LSB +: OHC_AH_W],
                                           OHC_ACC_HRS_MAX);
    wire [OHC_M_W-1:0] wr_acc_m = clamp_m(reg_wdata[OHC_AMIN_LSB +: OHC_M_W]);

    // borrowed value read in whole hours, minutes forced to zero
    wire [OHC_AH_W-1:0] ref_h = clamp_h({3'h0, ref_hours}, OHC_INT_HRS_MAX);
    wire ref_load = ref_sel & ~int_wr & ~load_pend
        & ((ref_h[OHC_IH_W-1:0] != int_h) | (int_m != 6'h00));
    wire int_change = int_wr | ref_load;
    wire [OHC_AH_W-1:0] kin_int_h = clamp_h({3'h0, keep_interval_in[OHC_IH_W-1:0]},
                                            OHC_INT_HRS_MAX);
    wire [OHC_AH_W-1:0] kin_rem_h = clamp_h({3'h0, keep_remain_in[OHC_IH_W-1:0]},
                                            OHC_INT_HRS_MAX);

    // ---------------------------------------------------------------
    // scan tick and minute tick
    // ---------------------------------------------------------------
    wire scan_tick = scan_cnt == SCW'(SCAN_CYCLES - 1);
    // monitor is sampled once per scan, so pulses shorter than a scan may be missed
    wire on_scan = scan_tick & monitor_in;
    wire minute_tick = on_scan & (on_cnt == MCW'(SCANS_PER_MIN - 1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scan_cnt <= '0;
            on_cnt <= '0;
        end
        else
        begin
            scan_cnt <= scan_tick ? '0 : scan_cnt + 1'b1;
            if (on_scan)
            begin
                on_cnt <= minute_tick ? '0 : on_cnt + 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // reset input edges and alarm
    // ---------------------------------------------------------------
    wire svc_edge = svc_reset_in & ~svc_prev & ~load_pend;
    wire clr_edge = full_clear_in & ~clr_prev & ~load_pend;
    wire rem_zero = (rem_h == 14'h0000) & (rem_m == 6'h00);
    wire acc_full = acc_h == OHC_ACC_HRS_MAX;
    wire alarm_clr = svc_reset_in | full_clear_in | (policy_idle & ~monitor_in);
    wire next_alarm = rem_zero & ~alarm_clr & ~load_pend;

    // ---------------------------------------------------------------
    // remaining time from a preset: interval - (accum % interval)
    // ---------------------------------------------------------------
    wire [OHC_TOT_W-1:0] int_tot = hm_total({3'h0, int_h}, int_m);
    wire [OHC_TOT_W-1:0] preset_tot = hm_total(wr_acc_h, wr_acc_m);
    wire int_zero = int_tot == 23'h000000;
    logic div_done;
    logic [OHC_TOT_W-1:0] div_quot, div_rem;
    wire div_start = (preset_ok & ~int_zero) | ((state == OHC_ST_MOD) & div_done);
    wire [OHC_TOT_W-1:0] div_a = (state == OHC_ST_MOD) ? int_tot - div_rem : preset_tot;
    wire [OHC_TOT_W-1:0] div_b = (state == OHC_ST_MOD) ? OHC_MIN_PER_HOUR : int_tot;
    wire split_done = (state == OHC_ST_SPLIT) & div_done;

    ohc_divider #(
        .W(OHC_TOT_W)
    ) i_ohc_divider (
        .clk(clk),
        .rst_n(rst_n),
        .start(div_start),
        .dividend(div_a),
        .divisor(div_b),
        .busy(),
        .done(div_done),
        .quot(div_quot),
        .rem(div_rem)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= OHC_ST_IDLE;
        end
        else
        begin
            case (state)
                OHC_ST_IDLE: state <= (preset_ok & ~int_zero) ? OHC_ST_MOD : OHC_ST_IDLE;
                OHC_ST_MOD: state <= div_done ? OHC_ST_SPLIT : OHC_ST_MOD;
                OHC_ST_SPLIT: state <= div_done ? OHC_ST_IDLE : OHC_ST_SPLIT;
                default: state <= OHC_ST_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // counter next values
    // ---------------------------------------------------------------
    always_comb
    begin
        next_int_h = int_h;
        next_int_m = int_m;
        next_rem_h = rem_h;
        next_rem_m = rem_m;
        next_acc_h = acc_h;
        next_acc_m = acc_m;
        if (load_pend)
        begin
            // retained values come back from the backup store after power up
            next_int_h = kin_int_h[OHC_IH_W-1:0];
            next_int_m = clamp_m(keep_interval_in[OHC_IW-1:OHC_IH_W]);
            next_rem_h = kin_rem_h[OHC_IH_W-1:0];
            next_rem_m = clamp_m(keep_remain_in[OHC_IW-1:OHC_IH_W]);
            next_acc_h = clamp_h(keep_accum_in[OHC_AH_W-1:0], OHC_ACC_HRS_MAX);
            next_acc_m = clamp_m(keep_accum_in[OHC_AW-1:OHC_AH_W]);
        end
        else
        begin
            if (clr_edge)
            begin
                next_acc_h = '0;
                next_acc_m = '0;
            end
            else if (preset_ok)
            begin
                next_acc_h = wr_acc_h;
                next_acc_m = wr_acc_m;
            end
            else if (minute_tick & ~acc_full)
            begin
                // counts independent of the service reset level
                next_acc_m = (acc_m == OHC_MIN_MAX) ? 6'h00 : acc_m + 6'h01;
                next_acc_h = (acc_m == OHC_MIN_MAX) ? acc_h + 17'h00001 : acc_h;
                if ((acc_m == OHC_MIN_MAX) & (acc_h + 17'h00001 == OHC_ACC_HRS_MAX))
                begin
                    next_acc_m = 6'h00; // stop at the limit, never wrap
                end
            end
            if (int_wr)
            begin
                next_int_h = wr_int_h[OHC_IH_W-1:0];
                next_int_m = wr_int_m;
            end
            else if (ref_load)
            begin
                next_int_h = ref_h[OHC_IH_W-1:0];
                next_int_m = 6'h00;
            end
            if (clr_edge | svc_edge | int_change)
            begin
                // interval change copies straight in, no recalculation
                next_rem_h = next_int_h;
                next_rem_m = next_int_m;
            end
            else if (preset_ok & int_zero)
            begin
                next_rem_h = '0;
                next_rem_m = '0;
            end
            else if (split_done)
            begin
                next_rem_h = div_quot[OHC_IH_W-1:0];
                next_rem_m = div_rem[OHC_M_W-1:0];
            end
            else if (minute_tick & ~rem_zero & (state == OHC_ST_IDLE))
            begin
                next_rem_m = (rem_m == 6'h00) ? OHC_MIN_MAX : rem_m - 6'h01;
                next_rem_h = (rem_m == 6'h00) ? rem_h - 14'h0001 : rem_h;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_pend <= 1'b1;
            int_h <= '0;
            int_m <= '0;
            rem_h <= '0;
            rem_m <= '0;
            acc_h <= '0;
            acc_m <= '0;
            svc_prev <= 1'b0;
            clr_prev <= 1'b0;
            alarm_out <= 1'b0;
            acc_full_q <= 1'b0;
        end
        else
        begin
            load_pend <= 1'b0;
            int_h <= next_int_h;
            int_m <= next_int_m;
            rem_h <= next_rem_h;
            rem_m <= next_rem_m;
            acc_h <= next_acc_h;
            acc_m <= next_acc_m;
            svc_prev <= svc_reset_in;
            clr_prev <= full_clear_in;
            alarm_out <= next_alarm;
            acc_full_q <= acc_full & ~load_pend;
        end
    end

    assign keep_interval_out = {int_m, int_h};
    assign keep_remain_out = {rem_m, rem_h};
    assign keep_accum_out = {acc_m, acc_h};

    // ---------------------------------------------------------------
    // control, interrupts and read port
    // ---------------------------------------------------------------
    wire [OHC_EV_W-1:0] events = {preset_refused, acc_full & ~acc_full_q & ~load_pend,
                                  next_alarm & ~alarm_out};
    wire [OHC_EV_W-1:0] w1c = (reg_wr & hit_stat) ? reg_wdata[OHC_EV_W-1:0] : '0;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= OHC_CTRL_RST;
            mask <= OHC_MASK_RST;
            status <= '0;
            reg_rdata <= '0;
        end
        else
        begin
            if (reg_wr & hit_ctrl)
            begin
                ctrl <= reg_wdata[OHC_CTRL_W-1:0];
            end
            if (reg_wr & hit_mask)
            begin
                mask <= reg_wdata[OHC_EV_W-1:0];
            end
            // a new event wins over a clear in the same cycle
            status <= (status & ~w1c) | events;
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
        end
    end

    assign irq = |(status & mask);

    assign rd_mux = hit_ctrl ? {29'h0, ctrl}
        : hit_int ? {10'h0, int_m, 2'h0, int_h}
        : hit_acc ? {2'h0, acc_m, 7'h0, acc_h}
        : hit_rem ? {10'h0, rem_m, 2'h0, rem_h}
        : hit_stat ? {29'h0, status}
        : hit_mask ? {29'h0, mask}
        : hit_state ? {28'h0, state != OHC_ST_IDLE, acc_full, monitor_in, alarm_out}
        : 32'h00000000;

endmodule
`default_nettype wire

// ===== src/ohc_pkg.sv
// constants, field layout and timing for the operating hours counter
// Behaviour
// - service reset rising edge clears alarm, reloads remaining time, keeps accumulated hours
// - full clear rising edge clears alarm, zeroes accumulated hours, reloads remaining time
// - monitor high advances accumulated and reduces remaining; monitor low holds both
// - alarm goes high once remaining time has reached zero
// - reset-only policy drops alarm only while a reset input is high
// - idle policy also drops alarm while monitor input is low
// - interval, remaining and accumulated values are always retained across power loss
// - service interval spans 0 to 9999 hours and 0 to 59 minutes
// - accumulated hours span 0 to 99999 hours, 0 to 59 minutes, presettable
// - accumulation continues while monitor high, whatever the service reset does
// - accumulated hours saturate at 99999 hours, no wrap
// - preset accumulated value gives remaining as interval minus accumulated modulo interval
// - run mode refuses accumulated preset; interval change just copies into remaining
// - interval taken from another value is read in whole hours
package ohc_pkg;

    // ---------------------------------------------------------------
    // field widths and limits
    // ---------------------------------------------------------------
    localparam int OHC_IH_W = 14;
    localparam int OHC_AH_W = 17;
    localparam int OHC_M_W = 6;
    localparam int OHC_IW = OHC_M_W + OHC_IH_W;
    localparam int OHC_AW = OHC_M_W + OHC_AH_W;
    localparam int OHC_TOT_W = 23;
    localparam logic [OHC_AH_W-1:0] OHC_INT_HRS_MAX = 17'h0270F;
    localparam logic [OHC_AH_W-1:0] OHC_ACC_HRS_MAX = 17'h1869F;
    localparam logic [OHC_M_W-1:0] OHC_MIN_MAX = 6'h3B;
    localparam logic [OHC_TOT_W-1:0] OHC_MIN_PER_HOUR = 23'h00003C;

    // ---------------------------------------------------------------
    // register map, byte addresses
    // ---------------------------------------------------------------
    localparam int OHC_ADDR_W = 8;
    localparam logic [7:0] OHC_REG_CTRL = 8'h00;
    localparam logic [7:0] OHC_REG_INTERVAL = 8'h04;
    localparam logic [7:0] OHC_REG_ACCUM = 8'h08;
    localparam logic [7:0] OHC_REG_REMAIN = 8'h0C;
    localparam logic [7:0] OHC_REG_STATUS = 8'h10;
    localparam logic [7:0] OHC_REG_MASK = 8'h14;
    localparam logic [7:0] OHC_REG_STATE = 8'h18;

    // field positions
    localparam int OHC_CTRL_POLICY = 0;
    localparam int OHC_CTRL_RUN = 1;
    localparam int OHC_CTRL_REF = 2;
    localparam int OHC_CTRL_W = 3;
    localparam int OHC_HRS_LSB = 0;
    localparam int OHC_IMIN_LSB = 16;
    localparam int OHC_AMIN_LSB = 24;
    localparam int OHC_EV_ALARM = 0;
    localparam int OHC_EV_SAT = 1;
    localparam int OHC_EV_REFUSED = 2;
    localparam int OHC_EV_W = 3;

    // reset values
    localparam logic [OHC_CTRL_W-1:0] OHC_CTRL_RST = 3'h0;
    localparam logic [OHC_EV_W-1:0] OHC_MASK_RST = 3'h0;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam longint OHC_CLK_PERIOD_PS = 8000;
    localparam longint OHC_SCAN_PERIOD_MS = 10;
    localparam longint OHC_MINUTE_S = 60;
    localparam int OHC_SCAN_CYCLES = int'((OHC_SCAN_PERIOD_MS * 64'd1000000000
        + OHC_CLK_PERIOD_PS - 1) / OHC_CLK_PERIOD_PS);
    localparam int OHC_SCANS_PER_MIN = int'((OHC_MINUTE_S * 64'd1000) / OHC_SCAN_PERIOD_MS);

endpackage

// ===== src/ohc_divider.sv
// sequential restoring divider giving quotient and remainder
`timescale 1ns/1ps
`default_nettype none
module ohc_divider #(
    parameter int W = 23
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    output logic busy,
    output logic done,
    output logic [W-1:0] quot,
    output logic [W-1:0] rem
);
    localparam int CW = $clog2(W + 1);

    logic [W-1:0] dsr;
    logic [CW-1:0] cnt;
    logic [W:0] shifted;
    logic [W:0] trial;

    // ---------------------------------------------------------------
    // one quotient bit per cycle
    // ---------------------------------------------------------------
    assign shifted = {rem, quot[W-1]};
    assign trial = shifted - {1'b0, dsr};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            quot <= '0;
            rem <= '0;
            dsr <= '0;
            cnt <= '0;
        end
        else if (start)
        begin
            busy <= 1'b1;
            done <= 1'b0;
            quot <= dividend;
            rem <= '0;
            dsr <= divisor;
            cnt <= CW'(W);
        end
        else if (busy)
        begin
            quot <= {quot[W-2:0], ~trial[W]};
            rem <= trial[W] ? shifted[W-1:0] : trial[W-1:0];
            cnt <= cnt - 1'b1;
            busy <= (cnt != CW'(1));
            done <= (cnt == CW'(1));
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== dv/ohc_props.sv
// concurrent checks on the operating hours counter ports
`timescale 1ns/1ps
`default_nettype none
module ohc_props import ohc_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic monitor_in,
    input wire logic svc_reset_in,
    input wire logic full_clear_in,
    input wire logic [OHC_IW-1:0] keep_interval_out,
    input wire logic [OHC_IW-1:0] keep_remain_out,
    input wire logic [OHC_AW-1:0] keep_accum_out,
    input wire logic alarm_out,
    input wire logic [OHC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr
);
    localparam logic [OHC_AW-1:0] ACC_TOP = {6'h00, OHC_ACC_HRS_MAX};
    logic pol;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // policy shadow: the control register is not visible at the pins
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            pol <= 1'h0;
        else if (reg_wr && reg_addr == OHC_REG_CTRL)
            pol <= reg_wdata[OHC_CTRL_POLICY];
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_rst_clr;
        svc_reset_in || full_clear_in |=> !alarm_out;
    endproperty
    a_rst_clr: assert property (p_rst_clr) else $error("alarm high after reset input");
    property p_idle_clr;
        (pol && !monitor_in) [*5] |=> !alarm_out;
    endproperty
    a_idle_clr: assert property (p_idle_clr) else $error("alarm high while idle");
    property p_alarm_set;
        $past(rst_n) && keep_remain_out == '0 && !svc_reset_in && !full_clear_in && !pol
            |=> alarm_out;
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm missing at zero");
    property p_alarm_cause;
        alarm_out |-> $past(keep_remain_out) == '0;
    endproperty
    a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without zero");
    property p_svc_reload;
        $past(rst_n) && $rose(svc_reset_in) && !full_clear_in
            |=> keep_remain_out == keep_interval_out;
    endproperty
    a_svc_reload: assert property (p_svc_reload) else $error("no reload on service");
    property p_full_reload;
        $past(rst_n) && $rose(full_clear_in)
            |=> keep_remain_out == keep_interval_out && keep_accum_out == '0;
    endproperty
    a_full_reload: assert property (p_full_reload) else $error("full clear missed");
    property p_hold;
        $past(rst_n) && !monitor_in && !$past(monitor_in) && !full_clear_in && !reg_wr
            |=> $stable(keep_accum_out);
    endproperty
    a_hold: assert property (p_hold) else $error("accum moved while idle");
    property p_sat;
        keep_accum_out == ACC_TOP && !full_clear_in && !reg_wr |=> keep_accum_out == ACC_TOP;
    endproperty
    a_sat: assert property (p_sat) else $error("accum left its limit");
    property p_range;
        keep_interval_out[OHC_IH_W-1:0] <= OHC_INT_HRS_MAX[OHC_IH_W-1:0]
            && keep_interval_out[OHC_IW-1:OHC_IH_W] <= OHC_MIN_MAX;
    endproperty
    a_range: assert property (p_range) else $error("interval out of range");
    c_alarm: cover property ($rose(alarm_out));
    c_full: cover property ($rose(full_clear_in));
    c_sat: cover property (keep_accum_out == ACC_TOP && monitor_in);
endmodule
bind ohc_top ohc_props i_ohc_props (.clk(clk), .rst_n(rst_n), .monitor_in(monitor_in),
    .svc_reset_in(svc_reset_in), .full_clear_in(full_clear_in), .alarm_out(alarm_out),
    .keep_interval_out(keep_interval_out), .keep_remain_out(keep_remain_out),
    .keep_accum_out(keep_accum_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr));
`default_nettype wire

// ===== dv/ohc_partner.sv
// model of the plant side: monitoring contact and the two reset contacts
`timescale 1ns/1ps
`default_nettype none
module ohc_partner (
    input wire logic clk,
    input wire logic run_req,
    input wire logic svc_req,
    input wire logic clr_req,
    output logic monitor_in,
    output logic svc_reset_in,
    output logic full_clear_in
);
    // contacts only move just after an edge, never mid-cycle
    initial
    begin
        monitor_in = 1'h0;
        svc_reset_in = 1'h0;
        full_clear_in = 1'h0;
    end
    always @(posedge clk)
    begin
        monitor_in <= run_req;
        svc_reset_in <= svc_req;
        full_clear_in <= clr_req;
    end
endmodule
`default_nettype wire

// ===== dv/tb_operating_hours_counter.sv
// self-checking bench for the operating hours counter
`timescale 1ns/1ps
`default_nettype none
module tb_operating_hours_counter import ohc_pkg::*; ;
    logic clk = 1'h0, rst_n = 1'h0, run_req = 1'h0, svc_req = 1'h0, clr_req = 1'h0;
    logic reg_wr = 1'h0, reg_rd = 1'h0;
    logic monitor_in, svc_reset_in, full_clear_in, alarm_out, irq;
    logic [OHC_ADDR_W-1:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [OHC_IH_W-1:0] ref_hours = 14'h0000;
    // restore image: interval over range, 2 min to go, 7 h 3 min run
    logic [OHC_IW-1:0] kint_in = 20'hFFFFF, krem_in = 20'h08000;
    logic [OHC_AW-1:0] kacc_in = 23'h060007;
    int num_errors = 0, cmp_count = 0, cyc_n = 0;
    ohc_top #(.SCAN_CYCLES(4), .SCANS_PER_MIN(3)) i_ohc_top (.clk(clk), .rst_n(rst_n),
        .monitor_in(monitor_in), .svc_reset_in(svc_reset_in), .full_clear_in(full_clear_in),
        .ref_hours(ref_hours), .keep_interval_in(kint_in), .keep_remain_in(krem_in),
        .keep_accum_in(kacc_in), .keep_interval_out(), .keep_remain_out(), .keep_accum_out(),
        .alarm_out(alarm_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    ohc_partner i_ohc_partner (.clk(clk), .run_req(run_req), .svc_req(svc_req),
        .clr_req(clr_req), .monitor_in(monitor_in), .svc_reset_in(svc_reset_in),
        .full_clear_in(full_clear_in));
    always #4 clk = ~clk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc_n++;
        if (cyc_n == 4000)
        begin
            num_errors++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk(nm, e, reg_rdata);
    endtask
    // n cycles of run time; multiples of 12 are whole minutes in this setup
    task automatic run(input int n);
        @(posedge clk);
        run_req <= 1'h1;
        cyc(n);
        run_req <= 1'h0;
        cyc(4);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_restore();
        rd(OHC_REG_INTERVAL, 32'h003B270F, "interval");
        rd(OHC_REG_REMAIN, 32'h00020000, "remain");
        rd(OHC_REG_ACCUM, 32'h03000007, "accum");
        rd(OHC_REG_MASK, 32'h0, "mask");
        rd(8'h1C, 32'h0, "unmapped");
        $display("test restore done");
    endtask
    task automatic t_count();
        wr(OHC_REG_INTERVAL, 32'h00020000);
        run(24);
        rd(OHC_REG_ACCUM, 32'h05000007, "accum");
        rd(OHC_REG_REMAIN, 32'h0, "remain");
        chk("alarm", 32'h1, {31'h0, alarm_out});
        rd(OHC_REG_STATUS, 32'h1, "status");
        wr(OHC_REG_MASK, 32'h1);
        #1 chk("irq", 32'h1, {31'h0, irq});
        wr(OHC_REG_STATUS, 32'h1);
        #1 chk("irq", 32'h0, {31'h0, irq});
        wr(OHC_REG_CTRL, 32'h1);
        cyc(8);
        chk("alarm", 32'h0, {31'h0, alarm_out});
        run(12);
        wr(OHC_REG_CTRL, 32'h0);
        cyc(2);
        chk("alarm", 32'h1, {31'h0, alarm_out});
        $display("test count done");
    endtask
    task automatic t_resets();
        @(posedge clk);
        svc_req <= 1'h1;
        run(24);
        rd(OHC_REG_ACCUM, 32'h08000007, "accum");
        chk("alarm", 32'h0, {31'h0, alarm_out});
        svc_req <= 1'h0;
        cyc(4);
        chk("alarm", 32'h1, {31'h0, alarm_out});
        svc_req <= 1'h1;
        cyc(2);
        svc_req <= 1'h0;
        cyc(3);
        rd(OHC_REG_REMAIN, 32'h00020000, "remain");
        rd(OHC_REG_ACCUM, 32'h08000007, "accum");
        chk("alarm", 32'h0, {31'h0, alarm_out});
        clr_req <= 1'h1;
        cyc(2);
        clr_req <= 1'h0;
        cyc(3);
        rd(OHC_REG_ACCUM, 32'h0, "accum");
        rd(OHC_REG_REMAIN, 32'h00020000, "remain");
        $display("test resets done");
    endtask
    task automatic t_preset();
        wr(OHC_REG_STATUS, 32'h7);
        wr(OHC_REG_INTERVAL, 32'h1E);
        wr(OHC_REG_ACCUM, 32'h64);
        cyc(80);
        rd(OHC_REG_REMAIN, 32'h14, "remain");
        wr(OHC_REG_CTRL, 32'h2);
        wr(OHC_REG_ACCUM, 32'h5);
        rd(OHC_REG_ACCUM, 32'h64, "accum");
        rd(OHC_REG_STATUS, 32'h4, "status");
        wr(OHC_REG_INTERVAL, 32'hA);
        rd(OHC_REG_REMAIN, 32'hA, "remain");
        @(posedge clk);
        ref_hours <= 14'h000C;
        wr(OHC_REG_CTRL, 32'h4);
        cyc(3);
        rd(OHC_REG_INTERVAL, 32'hC, "interval");
        rd(OHC_REG_REMAIN, 32'hC, "remain");
        wr(OHC_REG_CTRL, 32'h0);
        $display("test preset done");
    endtask
    task automatic t_sat();
        wr(OHC_REG_ACCUM, 32'h0001869F);
        cyc(80);
        run(24);
        rd(OHC_REG_ACCUM, 32'h0001869F, "accum");
        rd(OHC_REG_STATE, 32'h4, "state");
        $display("test saturate done");
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        cyc(2);
        t_restore();
        t_count();
        t_resets();
        t_preset();
        t_sat();
        conclude();
    end
endmodule
`default_nettype wire
